// ===== rtl/smbus_if.sv
// SMBus interface: configuration, control and status, byte engine and pins.
// Function
// R1: Enable bit turns interface on and watching.
// R2: Slave inhibit suppresses slave interrupts only.
// R3: Busy set by transfer, cleared on stop/timeout.
// R4: Extension bit selects normal or extended timing.
// R5: Extended setup eleven clocks, hold twelve.
// R6: Timeout timer reloads while SCL high.
// R7: Split timer: only high byte reloaded.
// R8: Software sets 25 ms timeout, resets interface.
// R9: Bus free after ten idle source periods.
// R10: Pending start issued right after free timeout.
// R11: Clock source field selects timer overflow.
// R12: Upper control bits form transfer status vector.
// R13: Start/stop flags report conditions since interrupt.
// R14: Start flag enters master, start when free.
// R15: Stop flag ends transfer after acknowledge.
// R16: Both flags: stop then start.
// R17: Acknowledge bit written outgoing, read received.
// R18: Acknowledge request set per received byte.
// R19: Software writes acknowledge before clearing interrupt.
// R20: Unwritten acknowledge sends a NACK.
// R21: SDA follows acknowledge write, SCL waits.
// R22: Unacknowledged slave address ignored until start.
// R23: Arbitration lost flag set, cleared with interrupt.
// R24: Interrupt on start, end, byte, arbitration.
// R25: Interrupt flag stalls bus, SCL held low.
// R26: Transmitter interrupt after ack, receiver before.
`timescale 1ns/1ps
`include "smbus_params.svh"
module smbus_if (
   // Clock and reset.
   input  wire logic                mclk,
   input  wire logic                rstn,
   // Special function register port.
   input  wire smbus_pkg::sfr_req_s sfr_req,
   output logic [7:0]               sfr_rdata,
   output logic                     irq,
   // Timer overflows and timeout timer control.
   input  wire logic [3:0]          tmr_ovf,
   input  wire logic                t3_split,
   output logic                     t3_reload_hi,
   output logic                     t3_reload_lo,
   // Bus pins.
   input  wire logic                scl_in,
   output logic                     scl_out,
   output logic                     scl_oe,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe
);
   logic [1:0]        rst_sync_ff;
   logic              rst_n;
   logic [1:0]        scl_sync_ff;
   logic [1:0]        sda_sync_ff;
   logic              scl_d_ff;
   logic              sda_d_ff;
   logic              scl;
   logic              sda;
   smbus_pkg::cfg_s   cfg_ff;
   smbus_pkg::ctl_s   wctl;
   smbus_pkg::mst_e   mst_ff;
   logic              busy_ff;
   logic [3:0]        free_cnt_ff;
   logic [4:0]        lowcnt_ff;
   logic [1:0]        tcnt_ff;
   logic              engaged_ff;
   logic [3:0]        bitcnt_ff;
   logic [7:0]        shift_ff;
   logic [7:0]        txbyte_ff;
   logic              master_ff;
   logic              tx_ff;
   logic              addr_ph_ff;
   logic              after_ack_ff;
   logic              sta_ff;
   logic              sto_ff;
   logic              ack_request_flag_ff;
   logic              arb_ff;
   logic              ack_ff;
   logic              si_ff;
   logic              scl_oe_ff;
   logic              sda_oe_ff;
   logic              t3_hi_ff;
   logic              t3_lo_ff;
   logic [7:0]        rdata_ff;
   logic              scl_rise;
   logic              start_det;
   logic              stop_det;
   logic              tick;
   logic              free_to;
   logic [4:0]        hold_n;
   logic [4:0]        setup_n;
   logic [7:0]        src;
   logic              drv_bit;
   logic              stall;
   logic              byte_rx;
   logic              ack_rise;
   logic              arb_lost;
   logic              slv_stop;
   logic              mst_start_done;
   logic              mst_stop_done;
   logic              ctl_wr;
   logic              si_clr;
   logic              rx_ready;
   logic              rx_valid;
   logic [7:0]        rx_data;

   // Reset is released through two flip-flops.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // Pins are synchronised and their edges found.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_in};
         sda_sync_ff <= {sda_sync_ff[0], sda_in};
         scl_d_ff    <= scl_sync_ff[1];
         sda_d_ff    <= sda_sync_ff[1];
      end
   end
   assign scl       = scl_sync_ff[1];
   assign sda       = sda_sync_ff[1];
   assign scl_rise  = scl && !scl_d_ff;
   assign start_det = cfg_ff.en && scl && scl_d_ff && sda_d_ff && !sda; // [R1]
   assign stop_det  = cfg_ff.en && scl && scl_d_ff && !sda_d_ff && sda;
   assign tick      = cfg_ff.en && tmr_ovf[cfg_ff.cs]; // [R11]

   assign hold_n  = cfg_ff.ext ? `SMB_HOLD_EXT : `SMB_HOLD_NORM; // [R4] [R5]
   assign setup_n = cfg_ff.ext ? `SMB_SETUP_EXT : `SMB_SETUP_NORM; // [R4] [R5]
   assign src     = (bitcnt_ff == 4'h0 && tx_ff) ? txbyte_ff : shift_ff;
   assign stall   = si_ff || !rx_ready; // [R25]

   assign byte_rx  = engaged_ff && scl_rise && bitcnt_ff == 4'h7 && !tx_ff; // [R26]
   assign ack_rise = engaged_ff && scl_rise && bitcnt_ff == 4'h8;
   assign arb_lost = engaged_ff && scl_rise && bitcnt_ff < 4'h8 && tx_ff && drv_bit && !sda; // [R23]
   assign slv_stop = engaged_ff && !master_ff && stop_det;
   assign mst_start_done = mst_ff == smbus_pkg::st_start && scl && tcnt_ff >= `SMB_LOW_TICKS;
   assign mst_stop_done  = mst_ff == smbus_pkg::st_stop && scl && tcnt_ff >= `SMB_LOW_TICKS;
   assign free_to  = cfg_ff.fte && tick && scl && sda && free_cnt_ff == `SMB_FREE_PERIODS;

   assign ctl_wr = sfr_req.wr && sfr_req.addr == `SMB_CTL_ADDR;
   assign wctl   = sfr_req.wdata;
   assign si_clr = ctl_wr && !wctl.si;

   // Value the engine wants on SDA in the current low phase.
   always_comb begin
      if (master_ff && after_ack_ff && bitcnt_ff == 4'h0 && (sto_ff || sta_ff)) begin
         drv_bit = !sto_ff; // [R15] [R16]
      end else if (bitcnt_ff == 4'h8) begin
         drv_bit = tx_ff || !ack_ff; // [R17] [R21]
      end else begin
         drv_bit = !tx_ff || src[7];
      end
   end

   // Configuration and data registers; the busy bit is kept apart.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff    <= `SMB_CFG_RESET;
         txbyte_ff <= `SMB_DAT_RESET;
      end else begin
         if (sfr_req.wr && sfr_req.addr == `SMB_CFG_ADDR) begin
            cfg_ff <= sfr_req.wdata & `SMB_CFG_WMASK;
         end
         if (sfr_req.wr && sfr_req.addr == `SMB_DAT_ADDR) begin
            txbyte_ff <= sfr_req.wdata;
         end
      end
   end

   // Busy tracking and bus free timeout.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff     <= 1'b0;
         free_cnt_ff <= 4'h0;
      end else begin
         if (!cfg_ff.en || !scl || !sda) begin
            free_cnt_ff <= 4'h0;
         end else if (tick && free_cnt_ff <= `SMB_FREE_PERIODS) begin
            free_cnt_ff <= free_cnt_ff + 4'h1; // [R9]
         end
         if (start_det) begin
            busy_ff <= 1'b1; // [R3]
         end else if (stop_det || free_to || !cfg_ff.en) begin
            busy_ff <= 1'b0; // [R3] [R9]
         end
      end
   end

   // Low phase length of SCL for setup and hold spacing.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lowcnt_ff <= 5'h00;
      end else if (scl) begin
         lowcnt_ff <= 5'h00;
      end else if (lowcnt_ff != 5'h1F) begin
         lowcnt_ff <= lowcnt_ff + 5'h01;
      end
   end

   // Byte engine and master sequencer.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mst_ff       <= smbus_pkg::st_idle;
         engaged_ff   <= 1'b0;
         bitcnt_ff    <= 4'h0;
         shift_ff     <= 8'h00;
         master_ff    <= 1'b0;
         tx_ff        <= 1'b0;
         addr_ph_ff   <= 1'b0;
         after_ack_ff <= 1'b0;
         tcnt_ff      <= 2'h0;
      end else if (!cfg_ff.en) begin
         mst_ff     <= smbus_pkg::st_idle; // [R1]
         engaged_ff <= 1'b0;
         master_ff  <= 1'b0;
         tx_ff      <= 1'b0;
      end else begin
         if (tick && tcnt_ff != 2'h3 && (scl || mst_ff != smbus_pkg::st_high)) begin
            tcnt_ff <= tcnt_ff + 2'h1;
         end
         if (start_det && !master_ff && mst_ff == smbus_pkg::st_idle) begin
            engaged_ff   <= !cfg_ff.slave_inhibit; // [R2] [R22]
            bitcnt_ff    <= 4'h0;
            tx_ff        <= 1'b0;
            addr_ph_ff   <= 1'b1;
            after_ack_ff <= 1'b0;
         end
         if (slv_stop) begin
            engaged_ff <= 1'b0;
         end
         if (engaged_ff && scl_rise && bitcnt_ff == 4'h8) begin
            bitcnt_ff    <= 4'h0;
            after_ack_ff <= 1'b1;
            addr_ph_ff   <= 1'b0;
            if (addr_ph_ff && !master_ff && !ack_ff) begin
               engaged_ff <= 1'b0; // [R22]
            end
            if (addr_ph_ff) begin
               tx_ff <= master_ff ^ shift_ff[0];
            end
         end else if (engaged_ff && scl_rise) begin
            shift_ff  <= {src[6:0], sda};
            bitcnt_ff <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'h0) begin
               after_ack_ff <= 1'b0;
            end
         end
         unique case (mst_ff)
            smbus_pkg::st_idle: begin
               if (sta_ff && !busy_ff) begin
                  mst_ff  <= smbus_pkg::st_start; // [R14] [R10]
                  tcnt_ff <= 2'h0;
               end
            end
            smbus_pkg::st_start: begin
               if (mst_start_done) begin
                  mst_ff       <= smbus_pkg::st_low;
                  master_ff    <= 1'b1; // [R14]
                  tx_ff        <= 1'b1;
                  engaged_ff   <= 1'b1;
                  bitcnt_ff    <= 4'h0;
                  addr_ph_ff   <= 1'b1;
                  after_ack_ff <= 1'b0;
                  tcnt_ff      <= 2'h0;
               end
            end
            smbus_pkg::st_low: begin
               if (!stall && tcnt_ff >= `SMB_LOW_TICKS && lowcnt_ff >= hold_n + setup_n) begin
                  tcnt_ff <= 2'h0;
                  if (after_ack_ff && bitcnt_ff == 4'h0 && sto_ff) begin
                     mst_ff <= smbus_pkg::st_stop; // [R15]
                  end else if (after_ack_ff && bitcnt_ff == 4'h0 && sta_ff) begin
                     mst_ff <= smbus_pkg::st_rstrt;
                  end else begin
                     mst_ff <= smbus_pkg::st_high;
                  end
               end
            end
            smbus_pkg::st_high: begin
               if (tcnt_ff >= `SMB_HIGH_TICKS) begin
                  mst_ff  <= smbus_pkg::st_low;
                  tcnt_ff <= 2'h0;
               end
            end
            smbus_pkg::st_stop: begin
               if (mst_stop_done) begin
                  mst_ff     <= smbus_pkg::st_idle; // [R16]
                  master_ff  <= 1'b0;
                  engaged_ff <= 1'b0;
                  tx_ff      <= 1'b0;
               end
            end
            smbus_pkg::st_rstrt: begin
               if (scl && tcnt_ff >= `SMB_LOW_TICKS) begin
                  mst_ff  <= smbus_pkg::st_start;
                  tcnt_ff <= 2'h0;
               end
            end
            default: begin
               mst_ff <= smbus_pkg::st_idle;
            end
         endcase
         if (arb_lost) begin
            mst_ff     <= smbus_pkg::st_idle; // [R23]
            engaged_ff <= 1'b0;
            master_ff  <= 1'b0;
            tx_ff      <= 1'b0;
         end
      end
   end

   // Control and status flags; a hardware set wins over a software clear.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         si_ff    <= 1'b0;
         arb_ff   <= 1'b0;
         sta_ff   <= 1'b0;
         sto_ff   <= 1'b0;
         ack_request_flag_ff <= 1'b0;
         ack_ff   <= 1'b0;
      end else begin
         si_ff    <= byte_rx || (ack_rise && tx_ff) || arb_lost || slv_stop // [R24] [R26]
                     || mst_start_done || (ctl_wr ? wctl.si : si_ff);
         arb_ff   <= arb_lost || (si_clr ? 1'b0 : arb_ff); // [R23]
         sta_ff   <= (byte_rx && addr_ph_ff && !master_ff) || (ctl_wr ? wctl.start_flag : sta_ff); // [R13]
         sto_ff   <= slv_stop || (!mst_stop_done && (ctl_wr ? wctl.stop_flag : sto_ff)); // [R13]
         ack_request_flag_ff <= byte_rx || (!ack_rise && ack_request_flag_ff); // [R18]
         if (byte_rx) begin
            ack_ff <= 1'b0; // [R20]
         end else if (ack_rise && tx_ff) begin
            ack_ff <= !sda; // [R17]
         end else if (ctl_wr) begin
            ack_ff <= wctl.ack; // [R17] [R19]
         end
      end
   end

   // Pin drivers and timeout timer control.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         t3_hi_ff  <= 1'b0;
         t3_lo_ff  <= 1'b0;
      end else begin
         scl_oe_ff <= cfg_ff.en && (mst_ff == smbus_pkg::st_low // [R25]
                      || (engaged_ff && !master_ff && stall && !scl));
         if (!cfg_ff.en) begin
            sda_oe_ff <= 1'b0;
         end else if (mst_ff == smbus_pkg::st_start) begin
            sda_oe_ff <= 1'b1;
         end else if (engaged_ff && !scl && lowcnt_ff >= hold_n) begin
            sda_oe_ff <= !drv_bit; // [R5] [R21]
         end else if (!engaged_ff) begin
            sda_oe_ff <= 1'b0;
         end
         t3_hi_ff <= cfg_ff.en && cfg_ff.toe && scl; // [R6]
         t3_lo_ff <= cfg_ff.en && cfg_ff.toe && scl && !t3_split; // [R7]
      end
   end

   // Register read port.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            `SMB_CTL_ADDR: rdata_ff <= {master_ff, tx_ff, sta_ff, sto_ff, // [R12]
                                        ack_request_flag_ff, arb_ff, ack_ff, si_ff};
            `SMB_CFG_ADDR: rdata_ff <= {cfg_ff.en, cfg_ff.slave_inhibit, busy_ff, cfg_ff[4:0]};
            `SMB_DAT_ADDR: rdata_ff <= rx_valid ? rx_data : 8'h00;
            default:       rdata_ff <= 8'h00;
         endcase
      end
   end

   smbus_rx_fifo #(
      .WIDTH (8),
      .DEPTH (2)
   ) u_rx_fifo (
      .clk       (mclk),
      .rst_n     (rst_n),
      .in_valid  (byte_rx),
      .in_ready  (rx_ready),
      .in_data   ({src[6:0], sda}),
      .out_valid (rx_valid),
      .out_ready (sfr_req.rd && sfr_req.addr == `SMB_DAT_ADDR),
      .out_data  (rx_data)
   );

   assign sfr_rdata    = rdata_ff;
   assign irq          = si_ff;
   assign scl_out      = 1'b0;
   assign sda_out      = 1'b0;
   assign scl_oe       = scl_oe_ff;
   assign sda_oe       = sda_oe_ff;
   assign t3_reload_hi = t3_hi_ff;
   assign t3_reload_lo = t3_lo_ff;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_busy_start: assert property (start_det |=> busy_ff) // [R3]
      else $error("busy not set after start");
   chk_busy_free: assert property (free_to && !start_det |=> !busy_ff) // [R9]
      else $error("busy not cleared by free timeout");
   chk_t3_reload: assert property (cfg_ff.en && cfg_ff.toe && scl |=> t3_reload_hi) // [R6]
      else $error("timeout timer not reloaded while scl high");
   chk_t3_split: assert property (t3_reload_lo |-> t3_reload_hi && !$past(t3_split)) // [R7]
      else $error("low byte reloaded in split mode");
   chk_rx_nack: assert property (byte_rx |=> ack_request_flag_ff && si_ff && !ack_ff ##1 ack_request_flag_ff) // [R20]
      else $error("received byte without request and default nack");
   chk_arb_clear: assert property ($fell(si_ff) |-> !arb_ff) // [R23]
      else $error("arbitration flag survives interrupt clear");
   chk_si_stall: assert property (si_ff && mst_ff == smbus_pkg::st_low
                                  |=> mst_ff == smbus_pkg::st_low && scl_oe) // [R25]
      else $error("master released scl while interrupt pending");
   chk_sda_hold: assert property ($changed(sda_oe_ff) && !scl && $past(scl) == 1'b0
                                  && $past(cfg_ff.en) |-> lowcnt_ff > hold_n) // [R5]
      else $error("sda changed inside hold window");
   chk_scl_setup: assert property ($fell(scl_oe_ff) && $past(master_ff) && cfg_ff.en
                                   |-> lowcnt_ff > hold_n + setup_n) // [R5]
      else $error("scl released before sda setup");

   cov_master_start: cover property (mst_start_done);
   cov_byte_rx: cover property (byte_rx ##[1:400] ack_rise);
   cov_stop_gen: cover property (mst_stop_done);
   cov_slave_stop: cover property (slv_stop);

endmodule : smbus_if

// ===== rtl/smbus_params.svh
// Register offsets, reset values and timing counts of the SMBus interface.
`ifndef SMBUS_PARAMS_SVH
`define SMBUS_PARAMS_SVH

`define SMB_CTL_ADDR     8'hC0
`define SMB_CFG_ADDR     8'hC1
`define SMB_DAT_ADDR     8'hC2
`define SMB_CFG_RESET    8'h00
`define SMB_CFG_WMASK    8'hDF
`define SMB_DAT_RESET    8'h00
`define SMB_HOLD_NORM    5'h03
`define SMB_HOLD_EXT     5'h0C
`define SMB_SETUP_NORM   5'h01
`define SMB_SETUP_EXT    5'h0B
`define SMB_FREE_PERIODS 4'hA
`define SMB_LOW_TICKS    2'h1
`define SMB_HIGH_TICKS   2'h2

`endif

// ===== rtl/smbus_pkg.sv
// Types shared by the SMBus interface files.
package smbus_pkg;

   typedef struct packed {
      logic       en;
      logic       slave_inhibit;
      logic       busy;
      logic       ext;
      logic       toe;
      logic       fte;
      logic [1:0] cs;
   } cfg_s;

   typedef struct packed {
      logic master;
      logic tx;
      logic start_flag;
      logic stop_flag;
      logic ack_request_flag;
      logic arb;
      logic ack;
      logic si;
   } ctl_s;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef enum logic [2:0] {st_idle, st_start, st_low, st_high, st_stop, st_rstrt} mst_e;

endpackage : smbus_pkg

// ===== rtl/smbus_rx_fifo.sv
// Two-entry receive buffer between the byte engine and the data register.
`timescale 1ns/1ps
module smbus_rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wptr_ff;
   logic [AW-1:0]    rptr_ff;
   logic [AW:0]      count_ff;
   logic             push;
   logic             pop;

   assign in_ready  = count_ff != (AW+1)'(DEPTH);
   assign out_valid = count_ff != '0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_ff[rptr_ff];

   // Storage is written only on an accepted push.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wptr_ff] <= in_data;
      end
   end

   // Pointers wrap at the depth and the count tracks occupancy.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_ff  <= '0;
         rptr_ff  <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wptr_ff <= (wptr_ff == AW'(DEPTH - 1)) ? '0 : wptr_ff + AW'(1);
         end
         if (pop) begin
            rptr_ff <= (rptr_ff == AW'(DEPTH - 1)) ? '0 : rptr_ff + AW'(1);
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : smbus_rx_fifo

// ===== verif/smbus_slave_model.sv
// Behavioural far-side slave that acknowledges writes, answers reads and may stretch SCL.
`timescale 1ns/1ps
module smbus_slave_model (
   // Bus lines.
   input  wire logic scl,
   input  wire logic sda,
   // Behaviour select.
   input  wire logic slow,
   // Open-drain pulls.
   output logic      scl_pull,
   output logic      sda_pull
);
   localparam logic [7:0] READ_BYTE = 8'hC5;
   int   bits;
   logic act;
   logic rd;
   logic addr_byte;
   initial begin
      bits = 0;
      act = 1'b0;
      rd = 1'b0;
      addr_byte = 1'b0;
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   always @(negedge sda) if (scl) begin
      act = 1'b1;
      bits = 0;
      rd = 1'b0;
      addr_byte = 1'b1;
   end
   always @(posedge sda) if (scl) act = 1'b0;
   // A read is chosen by the last address bit and ends on a NACK from the master.
   always @(posedge scl) if (act) begin
      bits++;
      if (bits == 8 && addr_byte) rd = sda;
      else if (bits == 9 && !addr_byte && sda) rd = 1'b0;
   end
   always @(negedge scl) if (act) begin
      if (bits == 8 && (addr_byte || !rd)) sda_pull = 1'b1;
      else if (bits == 9) begin
         sda_pull = rd && !READ_BYTE[7];
         bits = 0;
         addr_byte = 1'b0;
         if (slow) begin
            scl_pull = 1'b1;
            #1500 scl_pull = 1'b0;
         end
      end else if (rd && !addr_byte) begin
         sda_pull = (bits < 8) ? !READ_BYTE[7 - bits] : 1'b0;
      end
   end
endmodule : smbus_slave_model

// ===== verif/smbus_config_and_control_bench.sv
// Self-checking bench of the SMBus interface against a far-side slave model.
`timescale 1ns/1ps
module smbus_config_and_control_bench;
   logic                mclk;
   logic                rstn;
   smbus_pkg::sfr_req_s sfr_req;
   logic [7:0]          sfr_rdata;
   logic                irq;
   logic [3:0]          tmr_ovf = 4'h0;
   logic                t3_split;
   logic                t3_reload_hi;
   logic                t3_reload_lo;
   logic                scl_oe;
   logic                sda_oe;
   logic                scl_pull;
   logic                sda_pull;
   wire                 scl = !(scl_oe | scl_pull);
   wire                 sda = !(sda_oe | sda_pull);
   int                  bad_count;
   int                  comparisons;
   int                  cyc = 0;
   logic [7:0]          rv;
   logic [23:0]         rows [7] = '{24'hC1_5F_5F, 24'hC1_FF_DF, 24'hC1_01_01, 24'hC1_02_02,
                                     24'hC1_00_00, 24'h90_A5_00, 24'hC2_3C_00};
   smbus_if dut (.mclk(mclk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .irq(irq), .tmr_ovf(tmr_ovf), .t3_split(t3_split), .t3_reload_hi(t3_reload_hi),
      .t3_reload_lo(t3_reload_lo), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
   smbus_slave_model peer (.scl(scl), .sda(sda), .slow(1'b1), .scl_pull(scl_pull),
      .sda_pull(sda_pull));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      tmr_ovf <= (cyc % 8 == 0) ? 4'hF : 4'h0;
      if (cyc == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
      sfr_req <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge mclk);
      sfr_req <= '0;
      @(posedge mclk);
      rv = sfr_rdata;
   endtask : sfr
   task automatic wait_irq();
      for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge mclk);
      chk("irq", 8'h01, {7'h00, irq});
   endtask : wait_irq
   task automatic report_and_stop();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      bad_count = 0;
      comparisons = 0;
      rstn = 1'b0;
      sfr_req = '0;
      t3_split = 1'b0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      sfr(8'hC1, 1'b0, 8'h00);
      chk("cfg reset", 8'h00, rv);
      sfr(8'hC0, 1'b0, 8'h00);
      chk("ctl reset", 8'h00, rv);
      foreach (rows[i]) begin
         sfr(rows[i][23:16], 1'b1, rows[i][15:8]);
         sfr(rows[i][23:16], 1'b0, 8'h00);
         chk("reg row", rows[i][7:0], rv);
      end
      sfr(8'hC1, 1'b1, 8'h88);
      t3_split <= 1'b1;
      repeat (10) @(posedge mclk);
      chk("reload split", 8'h02, {6'h00, t3_reload_hi, t3_reload_lo});
      t3_split <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("reload whole", 8'h03, {6'h00, t3_reload_hi, t3_reload_lo});
      sfr(8'hC2, 1'b1, 8'hA0);
      sfr(8'hC0, 1'b1, 8'h20);
      wait_irq();
      sfr(8'hC0, 1'b0, 8'h00);
      chk("after start", 8'hE1, rv);
      sfr(8'hC1, 1'b0, 8'h00);
      chk("busy set", 8'hA8, rv);
      repeat (30) @(posedge mclk);
      chk("scl stall", 8'h00, {7'h00, scl});
      chk("reload off", 8'h00, {7'h00, t3_reload_hi});
      sfr(8'hC0, 1'b1, 8'h00);
      wait_irq();
      sfr(8'hC0, 1'b0, 8'h00);
      chk("after ack", 8'hC3, rv);
      sfr(8'hC0, 1'b1, 8'h10);
      repeat (400) @(posedge mclk);
      sfr(8'hC0, 1'b0, 8'h00);
      chk("after stop", 8'h00, rv);
      sfr(8'hC1, 1'b0, 8'h00);
      chk("busy clear", 8'h00, rv & 8'h20);
      chk("bus idle", 8'h03, {6'h00, scl, sda});
      sfr(8'hC2, 1'b1, 8'hA1);
      sfr(8'hC0, 1'b1, 8'h20);
      wait_irq();
      sfr(8'hC0, 1'b1, 8'h00);
      wait_irq();
      sfr(8'hC0, 1'b0, 8'h00);
      chk("read addr ack", 8'h83, rv);
      sfr(8'hC0, 1'b1, 8'h00);
      wait_irq();
      sfr(8'hC0, 1'b0, 8'h00);
      chk("rx pending", 8'h89, rv);
      sfr(8'hC2, 1'b0, 8'h00);
      chk("rx byte", 8'hC5, rv);
      sfr(8'hC0, 1'b1, 8'h03);
      repeat (40) @(posedge mclk);
      chk("ack drive", 8'h00, {6'h00, scl, sda});
      sfr(8'hC0, 1'b1, 8'h12);
      repeat (400) @(posedge mclk);
      sfr(8'hC0, 1'b0, 8'h00);
      chk("rx stop", 8'h02, rv);
      sfr(8'hC1, 1'b1, 8'h00);
      sfr(8'hC1, 1'b1, 8'h88);
      sfr(8'hC1, 1'b0, 8'h00);
      chk("re-enable", 8'h88, rv);
      report_and_stop();
   end
endmodule : smbus_config_and_control_bench
